// ### rtl/fss_pkg.sv
// Package: register map, field positions, reset values and encodings
package fss_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TFB_STATUS = 8'h1C;
  localparam logic [7:0] ADDR_SEL_LATCHED = 8'h1D;
  localparam logic [7:0] ADDR_SEL_LIVE = 8'h1E;
  localparam logic [7:0] ADDR_CLIP_MEM = 8'h18;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_TFB_STATUS = 8'h00;
  localparam logic [7:0] RST_SEL_LATCHED = 8'h17;
  localparam logic [7:0] RST_SEL_LIVE = 8'h00;

  // ----------------------------------------------------------------
  // Field positions, latched selection register
  // ----------------------------------------------------------------
  localparam int SL_PROT_SHUTDOWN = 6;
  localparam int SL_CLOCK_LOSS = 5;
  localparam int SL_OVER_TEMP = 4;
  localparam int SL_SUPPLY = 3;
  localparam int SL_DC_OFFSET = 2;
  localparam int SL_OVERCURRENT = 1;
  localparam int SL_CURRENT_LIMIT = 0;

  // ----------------------------------------------------------------
  // Field positions, live selection register
  // ----------------------------------------------------------------
  localparam int SV_WARNING = 6;
  localparam int SV_CLOCK_LOSS = 5;
  localparam int SV_OVER_TEMP = 4;
  localparam int SV_SUPPLY = 3;
  localparam int SV_LOAD_DIAG = 0;

  // ----------------------------------------------------------------
  // Attenuation code field and limits, protective-shutdown state code, clip width
  // ----------------------------------------------------------------
  localparam int TFB_ATTEN_W = 5;
  localparam logic [4:0] TFB_ATTEN_MAX = 5'h18;
  localparam logic [2:0] STATE_PROT_SHUTDOWN = 3'h5;
  localparam int CLIP_W = 4;

  // Bus access kinds
  typedef enum logic [1:0] {
    FSS_ACC_IDLE = 2'b00,
    FSS_ACC_READ = 2'b01,
    FSS_ACC_WRITE = 2'b10
  } fss_acc_e;

endpackage : fss_pkg

// ### rtl/fss_any_reduce.sv
// Per-channel OR reduction of one group of flag bits
module fss_any_reduce #(
  parameter int CH = 4,
  parameter int W = 1
) (
  input wire logic [CH*W-1:0] flags_i,
  output logic any_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CH < 1 || W < 1)
  begin : g_bad
    $error("fss_any_reduce: CH and W must be at least 1");
  end

  // ----------------------------------------------------------------
  // Reduction
  // ----------------------------------------------------------------
  wire logic [CH-1:0] ch_any;
  genvar gi;
  // One term per channel
  for (gi = 0; gi < CH; gi++)
  begin : g_ch
    assign ch_any[gi] = |flags_i[gi*W +: W];
  end
  assign any_o = |ch_any;

endmodule : fss_any_reduce

// ### rtl/fss_state_match.sv
// Detects any channel whose state code equals a given value
module fss_state_match #(
  parameter int CH = 4,
  parameter logic [2:0] CODE = 3'h5
) (
  input wire logic [CH*3-1:0] state_i,
  output logic match_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CH < 1)
  begin : g_bad
    $error("fss_state_match: CH must be at least 1");
  end

  // ----------------------------------------------------------------
  // Compare
  // ----------------------------------------------------------------
  wire logic [CH-1:0] hit;
  genvar gi;
  // Per channel equality
  for (gi = 0; gi < CH; gi++)
  begin : g_ch
    assign hit[gi] = (state_i[gi*3 +: 3] == CODE);
  end
  assign match_o = |hit;

endmodule : fss_state_match

// ### rtl/fss_fault_select.sv
// Fault signal source selection, thermal foldback status and clip memory
//
// Contract
// - Foldback attenuation reads as 5-bit code, 0.5 dB steps, 0 to 24.
// - Latched bit 6 raises fault while any channel state code is 101.
// - Latched bit 5 raises fault while stored clock-loss flag is set.
// - Latched bit 4, reset 1, raises fault on any stored over-temp shutdown.
// - Latched bit 3 raises fault on any stored supply fault.
// - Latched bit 2, reset 1, raises fault on any stored DC-offset fault.
// - Latched bit 1, reset 1, raises fault on any stored overcurrent fault.
// - Latched bit 0, reset 1, raises fault on any stored current-limit fault.
// - Live bit 6 raises fault while warning signal is active.
// - Live bit 5 raises fault while live clock-loss status is set.
// - Live bit 4 raises fault while any live over-temp shutdown is set.
// - Live bit 3 raises fault while any live supply status is set.
// - Live bit 0 raises fault while any load diagnostic is incomplete.
// - Clip-event memory clears to zero when read; an event in the reading cycle still sets its bit.
module fss_fault_select #(
  parameter int CH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port from the serial interface
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_hit_o,
  // Thermal foldback
  input wire logic [4:0] thermal_foldback_attenuation_i,
  // Channel state codes, three bits each
  input wire logic [CH*3-1:0] ch_state_i,
  // Stored fault flags
  input wire logic clock_loss_stored_i,
  input wire logic [CH-1:0] ch_over_temp_shutdown_stored_i,
  input wire logic over_temp_shutdown_stored_i,
  input wire logic battery_undervoltage_stored_i,
  input wire logic battery_overvoltage_stored_i,
  input wire logic power_stage_undervoltage_stored_i,
  input wire logic power_stage_overvoltage_stored_i,
  input wire logic digital_supply_power_on_reset_stored_i,
  input wire logic gate_drive_supply_error_stored_i,
  input wire logic [CH-1:0] dc_offset_error_stored_i,
  input wire logic [CH-1:0] overcurrent_error_stored_i,
  input wire logic [CH-1:0] current_limit_error_stored_i,
  // Live status flags
  input wire logic warning_active_i,
  input wire logic clock_loss_i,
  input wire logic [CH-1:0] ch_over_temp_shutdown_i,
  input wire logic over_temp_shutdown_i,
  input wire logic battery_undervoltage_i,
  input wire logic battery_overvoltage_i,
  input wire logic power_stage_undervoltage_i,
  input wire logic power_stage_overvoltage_i,
  input wire logic gate_drive_supply_error_i,
  input wire logic [CH-1:0] load_diag_completion_i,
  // Clip events, one-cycle pulses per channel
  input wire logic [CH-1:0] clip_event_i,
  output logic [CH-1:0] clip_stored_o,
  // Fault indication, high when a fault is flagged
  output logic fault_o
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (CH < 1 || CH > fss_pkg::CLIP_W)
  begin : g_bad
    $error("fss_fault_select: CH must be 1 to 4");
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [6:0] sel_latched_r;
  logic [6:0] sel_live_r;
  logic [4:0] atten_r;
  logic [CH-1:0] clip_mem_r;
  logic [CH-1:0] clip_mem_nxt;
  logic fault_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic hit_r;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic sel_tfb = (reg_addr_i == fss_pkg::ADDR_TFB_STATUS);
  wire logic sel_lat = (reg_addr_i == fss_pkg::ADDR_SEL_LATCHED);
  wire logic sel_liv = (reg_addr_i == fss_pkg::ADDR_SEL_LIVE);
  wire logic sel_clip = (reg_addr_i == fss_pkg::ADDR_CLIP_MEM);
  wire logic any_sel = sel_tfb | sel_lat | sel_liv | sel_clip;
  wire logic wr_lat = reg_wr_i & sel_lat;
  wire logic wr_liv = reg_wr_i & sel_liv;
  wire logic rd_clip = reg_rd_i & sel_clip;

  // Access kind, read wins if both strobes arrive together
  wire fss_pkg::fss_acc_e acc = reg_rd_i ? fss_pkg::FSS_ACC_READ :
                                reg_wr_i ? fss_pkg::FSS_ACC_WRITE : fss_pkg::FSS_ACC_IDLE;

  // ----------------------------------------------------------------
  // Source reduction
  // ----------------------------------------------------------------
  logic prot_shutdown_any;
  logic ot_stored_ch_any;
  logic dc_any;
  logic oc_any;
  logic il_any;
  logic ot_live_ch_any;
  logic ldg_done_all;

  fss_state_match #(.CH(CH), .CODE(fss_pkg::STATE_PROT_SHUTDOWN)) u_prot (
    .state_i(ch_state_i),
    .match_o(prot_shutdown_any)
  );
  fss_any_reduce #(.CH(CH), .W(1)) u_ot_st (
    .flags_i(ch_over_temp_shutdown_stored_i),
    .any_o(ot_stored_ch_any)
  );
  fss_any_reduce #(.CH(CH), .W(1)) u_dc (
    .flags_i(dc_offset_error_stored_i),
    .any_o(dc_any)
  );
  fss_any_reduce #(.CH(CH), .W(1)) u_oc (
    .flags_i(overcurrent_error_stored_i),
    .any_o(oc_any)
  );
  fss_any_reduce #(.CH(CH), .W(1)) u_il (
    .flags_i(current_limit_error_stored_i),
    .any_o(il_any)
  );
  fss_any_reduce #(.CH(CH), .W(1)) u_ot_lv (
    .flags_i(ch_over_temp_shutdown_i),
    .any_o(ot_live_ch_any)
  );
  assign ldg_done_all = &load_diag_completion_i;

  // Grouped supply sources
  wire logic supply_stored_any = battery_undervoltage_stored_i | battery_overvoltage_stored_i |
                                 power_stage_undervoltage_stored_i |
                                 power_stage_overvoltage_stored_i |
                                 digital_supply_power_on_reset_stored_i |
                                 gate_drive_supply_error_stored_i;
  wire logic supply_live_any = battery_undervoltage_i | battery_overvoltage_i |
                               power_stage_undervoltage_i | power_stage_overvoltage_i |
                               gate_drive_supply_error_i;

  // ----------------------------------------------------------------
  // Gated fault terms
  // ----------------------------------------------------------------
  wire logic t_prot = sel_latched_r[fss_pkg::SL_PROT_SHUTDOWN] & prot_shutdown_any;
  wire logic t_clk_st = sel_latched_r[fss_pkg::SL_CLOCK_LOSS] & clock_loss_stored_i;
  wire logic t_ot_st = sel_latched_r[fss_pkg::SL_OVER_TEMP] &
                       (ot_stored_ch_any | over_temp_shutdown_stored_i);
  wire logic t_sup_st = sel_latched_r[fss_pkg::SL_SUPPLY] & supply_stored_any;
  wire logic t_dc = sel_latched_r[fss_pkg::SL_DC_OFFSET] & dc_any;
  wire logic t_oc = sel_latched_r[fss_pkg::SL_OVERCURRENT] & oc_any;
  wire logic t_il = sel_latched_r[fss_pkg::SL_CURRENT_LIMIT] & il_any;
  wire logic t_warn = sel_live_r[fss_pkg::SV_WARNING] & warning_active_i;
  wire logic t_clk_lv = sel_live_r[fss_pkg::SV_CLOCK_LOSS] & clock_loss_i;
  wire logic t_ot_lv = sel_live_r[fss_pkg::SV_OVER_TEMP] &
                       (ot_live_ch_any | over_temp_shutdown_i);
  wire logic t_sup_lv = sel_live_r[fss_pkg::SV_SUPPLY] & supply_live_any;
  wire logic t_ldg = sel_live_r[fss_pkg::SV_LOAD_DIAG] & ~ldg_done_all;

  // Combined indication
  wire logic fault_nxt = t_prot | t_clk_st | t_ot_st | t_sup_st | t_dc | t_oc | t_il |
                         t_warn | t_clk_lv | t_ot_lv | t_sup_lv | t_ldg;

  // ----------------------------------------------------------------
  // Clip memory next value
  // ----------------------------------------------------------------
  // A read clears the memory but a same-cycle event still sets it
  always_comb
  begin
    clip_mem_nxt = rd_clip ? '0 : clip_mem_r;
    clip_mem_nxt = clip_mem_nxt | clip_event_i;
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  always_comb
  begin
    rdata_nxt = 8'h00;
    if (sel_tfb)
    begin
      rdata_nxt = {3'h0, atten_r};
    end
    else if (sel_lat)
    begin
      rdata_nxt = {1'b0, sel_latched_r};
    end
    else if (sel_liv)
    begin
      rdata_nxt = {1'b0, sel_live_r[6:3], 2'b00, sel_live_r[0]};
    end
    else if (sel_clip)
    begin
      rdata_nxt = {{(8 - CH){1'b0}}, clip_mem_r};
    end
  end

  // ----------------------------------------------------------------
  // Selection registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sel_latched_r <= fss_pkg::RST_SEL_LATCHED[6:0];
      sel_live_r <= fss_pkg::RST_SEL_LIVE[6:0];
    end
    else
    begin
      if (wr_lat && acc == fss_pkg::FSS_ACC_WRITE)
      begin
        sel_latched_r <= reg_wdata_i[6:0];
      end
      if (wr_liv && acc == fss_pkg::FSS_ACC_WRITE)
      begin
        sel_live_r <= {reg_wdata_i[6:3], 2'b00, reg_wdata_i[0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // Attenuation capture
  // ----------------------------------------------------------------
  // Clamp out-of-range codes to the deepest step
  wire logic atten_over = (thermal_foldback_attenuation_i > fss_pkg::TFB_ATTEN_MAX);
  wire logic [4:0] atten_nxt = atten_over ? fss_pkg::TFB_ATTEN_MAX :
                               thermal_foldback_attenuation_i;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      atten_r <= fss_pkg::RST_TFB_STATUS[4:0];
    end
    else
    begin
      atten_r <= atten_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Clip memory
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      clip_mem_r <= '0;
    end
    else
    begin
      clip_mem_r <= clip_mem_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Fault output
  // ----------------------------------------------------------------
  // Registered so the pin never glitches while sources settle
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fault_r <= 1'b0;
    end
    else
    begin
      fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read data register
  // ----------------------------------------------------------------
  // Only a read refreshes the data, so it stands until the next read
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_r <= 8'h00;
    end
    else
    begin
      if (acc == fss_pkg::FSS_ACC_READ)
      begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  // ----------------------------------------------------------------
  // Access acknowledge
  // ----------------------------------------------------------------
  // High for one cycle after any access to a mapped place
  wire logic hit_nxt = (acc != fss_pkg::FSS_ACC_IDLE) & any_sel;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      hit_r <= 1'b0;
    end
    else
    begin
      hit_r <= hit_nxt;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign reg_hit_o = hit_r;
  assign clip_stored_o = clip_mem_r;
  assign fault_o = fault_r;

endmodule : fss_fault_select

// ### verification/fss_fault_select_monitor.sv
// Checker for register port, clip memory and attenuation read-back
module fss_monitor #(
  parameter int CH = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic reg_rd_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_hit_o,
  input wire logic [4:0] thermal_foldback_attenuation_i,
  input wire logic [CH-1:0] clip_event_i,
  input wire logic [CH-1:0] clip_stored_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Address decode of the four mapped places
  wire logic mapped = reg_addr_i inside {8'h18, 8'h1C, 8'h1D, 8'h1E};
  // Read request at one address
  sequence s_rd(logic [7:0] a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  AST_ACCESS_HIT: assert property ((reg_rd_i || reg_wr_i) && mapped |=> reg_hit_o)
    else $error("hit missing after mapped access");
  AST_HIT_PULSE: assert property (!(reg_rd_i || reg_wr_i) |=> !reg_hit_o)
    else $error("hit without access");
  AST_UNMAPPED: assert property (reg_rd_i && !mapped |=> reg_rdata_o == 8'h00 && !reg_hit_o)
    else $error("unmapped read not refused");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved without read");
  AST_ATTEN_READ: assert property (s_rd(8'h1C) |=> reg_rdata_o == {3'h0,
    ($past(thermal_foldback_attenuation_i, 2) > 5'h18) ? 5'h18
    : $past(thermal_foldback_attenuation_i, 2)})
    else $error("attenuation read-back wrong");
  AST_CLIP_READ: assert property (s_rd(8'h18) |=> reg_rdata_o == 8'($past(clip_stored_o)))
    else $error("clip memory read wrong");
  AST_CLIP_CLEAR: assert property (s_rd(8'h18) and clip_event_i == '0 |=> clip_stored_o == '0)
    else $error("clip memory not cleared by read");
  AST_CLIP_SET: assert property (clip_event_i != '0 |=>
    (clip_stored_o & $past(clip_event_i)) == $past(clip_event_i))
    else $error("clip event not stored");
endmodule : fss_monitor

// ### verification/fss_host.sv
// Host model issuing single-byte register accesses
module fss_host (
  input wire logic clk_i,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_addr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i,
  input wire logic reg_hit_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // One strobe cycle; address and data scrambled when idle
  task automatic access(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    reg_rd_o = rd;
    reg_wr_o = !rd;
    reg_addr_o = a;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_wr_o = 1'b0;
    reg_addr_o = ~a;
    reg_wdata_o = ~d;
  endtask : access
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    access(1'b0, a, d);
  endtask : write_reg
  // Answer is settled by the falling edge after the taking edge
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic hit);
    access(1'b1, a, 8'h00);
    d = reg_rdata_i;
    hit = reg_hit_i;
  endtask : read_reg
endmodule : fss_host

// ### verification/fault_signal_source_select_bench.sv
// Self-checking bench for fault source selection
module fault_signal_source_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic rd, wr, hit, warn = 0, ck = 0, ck_st = 0;
  logic [7:0] addr, wdata, rdata;
  logic [4:0] att = 0, ot_st = 0, ot = 0, sp = 0;
  logic [5:0] sp_st = 0;
  logic [11:0] st = 12'h924;
  logic [3:0] dc = 0, oc = 0, il = 0, ldg = 4'hF, clip = 0, cs;
  logic fault;
  int n_errors = 0;
  int checked = 0;
  initial
  begin
    forever #4 clk_i = ~clk_i;
  end
  fss_host u_host (.clk_i(clk_i), .reg_rd_o(rd), .reg_wr_o(wr), .reg_addr_o(addr),
    .reg_wdata_o(wdata), .reg_rdata_i(rdata), .reg_hit_i(hit));
  fss_fault_select #(.CH(4)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .reg_rd_i(rd),
    .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .reg_hit_o(hit), .thermal_foldback_attenuation_i(att), .ch_state_i(st),
    .clock_loss_stored_i(ck_st), .ch_over_temp_shutdown_stored_i(ot_st[4:1]),
    .over_temp_shutdown_stored_i(ot_st[0]), .battery_undervoltage_stored_i(sp_st[0]),
    .battery_overvoltage_stored_i(sp_st[1]), .power_stage_undervoltage_stored_i(sp_st[2]),
    .power_stage_overvoltage_stored_i(sp_st[3]),
    .digital_supply_power_on_reset_stored_i(sp_st[4]),
    .gate_drive_supply_error_stored_i(sp_st[5]), .dc_offset_error_stored_i(dc),
    .overcurrent_error_stored_i(oc), .current_limit_error_stored_i(il),
    .warning_active_i(warn), .clock_loss_i(ck), .ch_over_temp_shutdown_i(ot[4:1]),
    .over_temp_shutdown_i(ot[0]), .battery_undervoltage_i(sp[0]),
    .battery_overvoltage_i(sp[1]), .power_stage_undervoltage_i(sp[2]),
    .power_stage_overvoltage_i(sp[3]), .gate_drive_supply_error_i(sp[4]),
    .load_diag_completion_i(ldg), .clip_event_i(clip), .clip_stored_o(cs), .fault_o(fault));
  // Compare and count
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input logic exp_hit);
    logic [7:0] d;
    logic h;
    u_host.read_reg(a, d, h);
    chk("read data", d, exp);
    chk("hit", {7'h0, h}, {7'h0, exp_hit});
  endtask : rd_chk
  // Drive one source group with a pattern, zero turns it off
  task automatic drive(input int s, input logic [5:0] v);
    @(negedge clk_i);
    case (s)
      0: st = v[0] ? 12'h005 : (v != 0 ? 12'hA00 : 12'h924);
      1: ck_st = |v;
      2: ot_st = v[4:0];
      3: sp_st = v;
      4: dc = v[3:0];
      5: oc = v[3:0];
      6: il = v[3:0];
      7: warn = |v;
      8: ck = |v;
      9: ot = v[4:0];
      10: sp = v[4:0];
      default: ldg = ~v[3:0];
    endcase
    repeat (2) @(negedge clk_i);
  endtask : drive
  // Reset values, reserved bits, read-only and unmapped places
  task automatic t_regs();
    chk("fault", {7'h0, fault}, 8'h00);
    rd_chk(8'h1D, fss_pkg::RST_SEL_LATCHED, 1'b1);
    rd_chk(8'h1E, fss_pkg::RST_SEL_LIVE, 1'b1);
    rd_chk(8'h1C, 8'h00, 1'b1);
    rd_chk(8'h1A, 8'h00, 1'b0);
    u_host.write_reg(8'h1D, 8'hFF);
    u_host.write_reg(8'h1E, 8'hFF);
    u_host.write_reg(8'h1C, 8'h55);
    rd_chk(8'h1D, 8'h7F, 1'b1);
    rd_chk(8'h1E, 8'h79, 1'b1);
    rd_chk(8'h1C, 8'h00, 1'b1);
    u_host.write_reg(8'h1D, 8'h17);
    u_host.write_reg(8'h1E, 8'h00);
  endtask : t_regs
  // Two enabled sources: fault holds until both drop
  task automatic t_or();
    drive(4, 6'h01);
    drive(5, 6'h01);
    drive(4, 6'h00);
    chk("fault", {7'h0, fault}, 8'h01);
    drive(5, 6'h00);
    chk("fault", {7'h0, fault}, 8'h00);
  endtask : t_or
  // Each source raises fault only while its selection bit is set
  task automatic t_sources();
    logic [5:0] pat [2] = '{6'h21, 6'h0A};
    int pos [12] = '{6, 5, 4, 3, 2, 1, 0, 6, 5, 4, 3, 0};
    logic [7:0] sel;
    for (int p = 0; p < 2; p++)
    begin
      for (int s = 0; s < 12; s++)
      begin
        sel = 8'h01 << pos[s];
        u_host.write_reg(8'h1D, s < 7 ? sel : 8'h00);
        u_host.write_reg(8'h1E, s < 7 ? 8'h00 : sel);
        drive(s, pat[p]);
        chk("fault on", {7'h0, fault}, 8'h01);
        u_host.write_reg(8'h1D, 8'h00);
        u_host.write_reg(8'h1E, 8'h00);
        repeat (2) @(negedge clk_i);
        chk("fault off", {7'h0, fault}, 8'h00);
        drive(s, 6'h00);
      end
    end
  endtask : t_sources
  // Attenuation codes at both ends of the range and beyond
  task automatic t_atten();
    logic [4:0] codes [5] = '{5'h00, 5'h01, 5'h17, 5'h18, 5'h1F};
    for (int i = 0; i < 5; i++)
    begin
      att = codes[i];
      repeat (2) @(negedge clk_i);
      rd_chk(8'h1C, {3'h0, codes[i] > 5'h18 ? 5'h18 : codes[i]}, 1'b1);
    end
  endtask : t_atten
  // Clip memory keeps events and clears on read
  task automatic t_clip();
    @(negedge clk_i);
    clip = 4'h5;
    @(negedge clk_i);
    clip = 4'h0;
    chk("clip stored", {4'h0, cs}, 8'h05);
    rd_chk(8'h18, 8'h05, 1'b1);
    chk("clip stored", {4'h0, cs}, 8'h00);
    // Event on the reading edge survives the clear
    clip = 4'hA;
    rd_chk(8'h18, 8'h0A, 1'b1);
    clip = 4'h0;
    chk("clip stored", {4'h0, cs}, 8'h0A);
    rd_chk(8'h18, 8'h0A, 1'b1);
    rd_chk(8'h18, 8'h00, 1'b1);
  endtask : t_clip
  // Reset in mid-run brings back the selection reset values
  task automatic t_reset();
    u_host.write_reg(8'h1D, 8'h00);
    dc = 4'h1;
    repeat (2) @(negedge clk_i);
    chk("fault", {7'h0, fault}, 8'h00);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    chk("fault", {7'h0, fault}, 8'h00);
    rst_n_i = 1'b1;
    repeat (2) @(negedge clk_i);
    chk("fault", {7'h0, fault}, 8'h01);
    rd_chk(8'h1D, fss_pkg::RST_SEL_LATCHED, 1'b1);
    dc = 4'h0;
    repeat (2) @(negedge clk_i);
    chk("fault", {7'h0, fault}, 8'h00);
  endtask : t_reset
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #100us;
    n_errors++;
    complete_run();
  end
  initial
  begin
    repeat (8) @(negedge clk_i);
    rst_n_i = 1'b1;
    @(negedge clk_i);
    t_regs();
    t_or();
    t_sources();
    t_atten();
    t_clip();
    t_reset();
    complete_run();
  end
endmodule : fault_signal_source_select_bench
bind fss_fault_select fss_monitor #(.CH(CH)) u_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .reg_rd_i(reg_rd_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
  .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
  .thermal_foldback_attenuation_i(thermal_foldback_attenuation_i),
  .clip_event_i(clip_event_i), .clip_stored_o(clip_stored_o));
